// >>> src/pss_top.sv
// power-save control and status readback through the common shift register
// Contract
// R1: select 00 never enters power save
// R2: 01 sleeps on zero latch, wakes on shift clock
// R3: 10 sleeps on zero, wakes on nonzero latch
// R4: 11 always saves; power-up selects 111
// R5: gate bit zero keeps grayscale clock running
// R6: gate bit one halts grayscale clock in save
// R7: select 00 never gates grayscale clock
// R8: latch copies shift register, then loads status
// R9: shift register msb set skips status load
// R10: no reload until a new bit shifted
// R11: controller re-shifts latched data to reread
// R12: serial output advances per shift clock edge
// R13: open flags 15..8 at bits 247:240
// R14: open flags 7..0 at bits 231:224
// R15: reserved status positions load zero
// R16: short flags at 215:208 and 199:192
// R17: leak flags at 183:176 and 167:160
// R18: thermal error 151, warning 150, refshort 149
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_top
   import pss_pkg::*;
#(
   parameter int WAKE_CYC = `PSS_WAKE_CYC
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RSTN_I,
   // serial link pins
   input wire logic SCLK_I,
   input wire logic LAT_I,
   input wire logic SIN_I,
   input wire logic GRAYSCALE_CLOCK_I,
   output logic SERIAL_OUTPUT_O,
   // fault inputs
   input wire logic [15:0] OPEN_FLAG_I,
   input wire logic [15:0] SHORT_FLAG_I,
   input wire logic [15:0] LEAK_FLAG_I,
   input wire logic TERR_FLAG_I,
   input wire logic TWARN_FLAG_I,
   input wire logic REFS_FLAG_I,
   // core status
   output logic GRAYSCALE_CLOCK_INT_O,
   output logic POWER_SAVING_O,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O
);
   initial begin
      if (WAKE_CYC < 1) $error("wake count must be at least one");
   end
   pss_edge_if e ();
   pss_pin_sync u_sync (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .sclk_i(SCLK_I),
      .lat_i(LAT_I),
      .sin_i(SIN_I),
      .grayscale_clock_i(GRAYSCALE_CLOCK_I),
      .e(e)
   );
   // ----------------------------------------
   // shift register and grayscale latch
   // ----------------------------------------
   logic [`PSS_SR_W-1:0] sr_r;
   logic [`PSS_GS_W-1:0] gs_r;
   logic [2:0] psel_r;
   logic loaded_r;
   logic gs_zero_r;
   pss_state_t st_r;
   logic [15:0] wake_r;
   logic sclk_d_r;
   logic skid_in_ready;
   logic skid_out_valid;
   logic skid_out_data;
   wire shift_go = e.sclk_rise && skid_in_ready;
   wire lat_go = e.lat_rise && !shift_go;
   // status image laid out on the common shift register; all else is zero
   wire [`PSS_SR_W-1:0] status_image = (`PSS_SR_W'(OPEN_FLAG_I[15:8]) << `PSS_OPEN_HI_POS)
      | (`PSS_SR_W'(OPEN_FLAG_I[7:0]) << `PSS_OPEN_LO_POS)
      | (`PSS_SR_W'(SHORT_FLAG_I[15:8]) << `PSS_SHORT_HI_POS)
      | (`PSS_SR_W'(SHORT_FLAG_I[7:0]) << `PSS_SHORT_LO_POS)
      | (`PSS_SR_W'(LEAK_FLAG_I[15:8]) << `PSS_LEAK_HI_POS)
      | (`PSS_SR_W'(LEAK_FLAG_I[7:0]) << `PSS_LEAK_LO_POS)
      | (`PSS_SR_W'(TERR_FLAG_I) << `PSS_TERR_POS)
      | (`PSS_SR_W'(TWARN_FLAG_I) << `PSS_TWARN_POS)
      | (`PSS_SR_W'(REFS_FLAG_I) << `PSS_REFS_POS); // R13 R14 R15 R16 R17 R18
   wire do_status = lat_go && !sr_r[`PSS_MSB] && !loaded_r; // R9 R10
   wire [`PSS_GS_W-1:0] gs_in = sr_r[`PSS_GS_W-1:0];
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         sr_r <= '0;
         gs_r <= '0;
         loaded_r <= 1'b0;
         gs_zero_r <= 1'b1;
      end else if (shift_go) begin
         sr_r <= {sr_r[`PSS_SR_W-2:0], e.sin_lvl}; // R12
         loaded_r <= 1'b0; // R10
      end else if (lat_go) begin
         gs_r <= gs_in; // R8
         gs_zero_r <= gs_in == '0;
         if (do_status) begin
            sr_r <= status_image; // R8
            loaded_r <= 1'b1;
         end
      end
   end
   // ----------------------------------------
   // serial output through the buffer
   // ----------------------------------------
   pss_skid #(.W(1)) u_skid (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .in_valid_i(shift_go),
      .in_ready_o(skid_in_ready),
      .in_data_i(sr_r[`PSS_MSB]),
      .out_valid_o(skid_out_valid),
      .out_ready_i(1'b1),
      .out_data_o(skid_out_data)
   );
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) SERIAL_OUTPUT_O <= 1'b0;
      else if (skid_out_valid) SERIAL_OUTPUT_O <= skid_out_data; // R12
   end
   // ----------------------------------------
   // power-save state
   // ----------------------------------------
   pss_mode_t mode;
   assign mode = pss_mode_t'(psel_r[1:0]);
   wire zero_latched = lat_go && (gs_in == '0);
   wire data_latched = lat_go && (gs_in != '0);
   wire gate_en = psel_r[2] && (mode != PSS_OFF); // R6 R7
   wire in_save = st_r == PSS_SAVE;
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         st_r <= PSS_SAVE;
         wake_r <= 16'h0;
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= e.sclk_rise;
         unique case (st_r)
            PSS_RUN: begin
               if (mode == PSS_ALWAYS) st_r <= PSS_SAVE; // R4
               else if (mode != PSS_OFF && zero_latched) st_r <= PSS_SAVE; // R2 R3
            end
            PSS_SAVE: begin
               wake_r <= 16'(WAKE_CYC);
               if (mode == PSS_OFF) st_r <= PSS_RUN; // R1
               else if (mode == PSS_ZERO_SCLK && e.sclk_rise) st_r <= PSS_WAKE; // R2
               else if (mode == PSS_ZERO_DATA && data_latched) st_r <= PSS_WAKE; // R3
            end
            PSS_WAKE: begin
               if (mode == PSS_ALWAYS) st_r <= PSS_SAVE;
               else if (wake_r <= 16'h1) st_r <= PSS_RUN;
               else wake_r <= wake_r - 16'h1;
            end
         endcase
      end
   end
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         POWER_SAVING_O <= 1'b1;
         GRAYSCALE_CLOCK_INT_O <= 1'b0;
      end else begin
         POWER_SAVING_O <= st_r != PSS_RUN;
         GRAYSCALE_CLOCK_INT_O <= e.grayscale_clock_lvl && !(gate_en && in_save); // R5 R6
      end
   end
   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   wire apb_acc = PSEL_I && PENABLE_I;
   wire hit_ctrl = PADDR_I == `PSS_APB_CTRL;
   wire hit_stat = PADDR_I == `PSS_APB_STAT;
   wire hit_gs = PADDR_I == `PSS_APB_GSLO;
   wire hit_any = hit_ctrl || hit_stat || hit_gs;
   wire [31:0] rd_mux = hit_ctrl ? {29'h0, psel_r}
      : hit_stat ? {27'h0, loaded_r, gs_zero_r, sr_r[`PSS_MSB], POWER_SAVING_O, in_save}
      : hit_gs ? gs_r[31:0] : 32'h0;
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         psel_r <= `PSS_PSEL_RST; // R4
         PRDATA_O <= 32'h0;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O <= PSEL_I && !PENABLE_I;
         PSLVERR_O <= PSEL_I && !PENABLE_I && !hit_any;
         if (PSEL_I && !PENABLE_I) PRDATA_O <= rd_mux;
         if (apb_acc && PREADY_O && PWRITE_I && hit_ctrl) psel_r <= PWDATA_I[2:0];
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   off_never_saves_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (mode == PSS_OFF) |=> ##1 !in_save) else $error("saved with select 00"); // R1
   always_save_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (mode == PSS_ALWAYS && st_r == PSS_RUN) |=> in_save) else $error("11 not saving"); // R4
   zero_enters_save_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (st_r == PSS_RUN && mode == PSS_ZERO_DATA && zero_latched) |=> in_save)
      else $error("no save on zero"); // R3
   sclk_wakes_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (in_save && mode == PSS_ZERO_SCLK && e.sclk_rise) |=> st_r == PSS_WAKE)
      else $error("no wake on sclk"); // R2
   gate_low_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (gate_en && in_save) |=> !GRAYSCALE_CLOCK_INT_O) else $error("gated clock high"); // R6
   gate_pass_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (!psel_r[2] || mode == PSS_OFF) |=> GRAYSCALE_CLOCK_INT_O == $past(e.grayscale_clock_lvl))
      else $error("clock gated wrongly"); // R5 R7
   status_load_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      do_status |=> sr_r == $past(status_image) && gs_r == $past(gs_in))
      else $error("status not loaded"); // R8
   msb_skip_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (lat_go && sr_r[`PSS_MSB]) |=> sr_r == $past(sr_r)) else $error("msb load"); // R9
   reload_block_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (lat_go && loaded_r) |=> sr_r == $past(sr_r)) else $error("double load"); // R10
   shift_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      shift_go |=> sr_r[0] == $past(e.sin_lvl)) else $error("bad shift"); // R12
   save_wake_c: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
      st_r == PSS_WAKE ##1 st_r == PSS_RUN);
   status_c: cover property (@(posedge CLK_I) disable iff (!RSTN_I) do_status);
   refused_c: cover property (@(posedge CLK_I) disable iff (!RSTN_I) lat_go && loaded_r);
endmodule

// >>> src/pss_defs.svh
// constants for the power-save and status readback block
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_SR_W 257
`define PSS_GS_W 256
`define PSS_MSB 256
`define PSS_PSEL_LO 134
`define PSS_PSEL_GATE 136
`define PSS_OPEN_HI_POS 240
`define PSS_OPEN_LO_POS 224
`define PSS_SHORT_HI_POS 208
`define PSS_SHORT_LO_POS 192
`define PSS_LEAK_HI_POS 176
`define PSS_LEAK_LO_POS 160
`define PSS_TERR_POS 151
`define PSS_TWARN_POS 150
`define PSS_REFS_POS 149
`define PSS_PSEL_RST 3'h7
`define PSS_WAKE_NS 1000
`define PSS_CLK_NS 10
`define PSS_WAKE_CYC ((`PSS_WAKE_NS + `PSS_CLK_NS - 1) / `PSS_CLK_NS)
`define PSS_APB_CTRL 12'h000
`define PSS_APB_STAT 12'h004
`define PSS_APB_GSLO 12'h008
`endif

// >>> src/pss_pkg.sv
// types for the power-save and status readback block
package pss_pkg;
   typedef enum logic [1:0] {PSS_OFF, PSS_ZERO_SCLK, PSS_ZERO_DATA, PSS_ALWAYS} pss_mode_t;
   typedef enum {PSS_RUN, PSS_SAVE, PSS_WAKE} pss_state_t;
endpackage

// >>> src/pss_edge_if.sv
// synchronised pin levels and edge pulses shared between modules
`timescale 1ns/1ps
interface pss_edge_if;
   logic sclk_rise;
   logic lat_rise;
   logic sin_lvl;
   logic grayscale_clock_lvl;
   modport src (output sclk_rise, output lat_rise, output sin_lvl, output grayscale_clock_lvl);
   modport dst (input sclk_rise, input lat_rise, input sin_lvl, input grayscale_clock_lvl);
endinterface

// >>> src/pss_pin_sync.sv
// two-flop synchronisers and rising edge detection for the link pins
`timescale 1ns/1ps
module pss_pin_sync (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic sclk_i,
   input wire logic lat_i,
   input wire logic sin_i,
   input wire logic grayscale_clock_i,
   pss_edge_if.src e
);
   logic [3:0] s1_r;
   logic [3:0] s2_r;
   logic [1:0] old_r;
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         old_r <= 2'h0;
      end else begin
         s1_r <= {grayscale_clock_i, sin_i, lat_i, sclk_i};
         s2_r <= s1_r;
         old_r <= s2_r[1:0];
      end
   end
   assign e.sclk_rise = s2_r[0] & ~old_r[0];
   assign e.lat_rise = s2_r[1] & ~old_r[1];
   assign e.sin_lvl = s2_r[2];
   assign e.grayscale_clock_lvl = s2_r[3];
endmodule

// >>> src/pss_skid.sv
// two-entry buffer for serial output bits
`timescale 1ns/1ps
module pss_skid #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   logic [W-1:0] mem_r [2];
   logic [1:0] cnt_r;
   logic rd_r;
   logic wr_r;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = cnt_r != 2'h2;
   assign out_valid_o = cnt_r != 2'h0;
   assign out_data_o = mem_r[rd_r];
   initial begin
      if (W < 1) $error("width must be positive");
   end
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cnt_r <= 2'h0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
      end else begin
         if (push) mem_r[wr_r] <= in_data_i;
         if (push) wr_r <= ~wr_r;
         if (pop) rd_r <= ~rd_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// >>> bench/pss_host_model.sv
// host controller model: shift clock, serial data and latch strobe
`timescale 1ns/1ps
module pss_host_model (
   input wire logic clk_i,
   input wire logic serial_output_i,
   output logic sclk_o,
   output logic sin_o,
   output logic lat_o
);
   initial begin
      sclk_o = 1'h0;
      sin_o = 1'h0;
      lat_o = 1'h0;
   end
   // one 160 ns shift clock period; the output shows the bit pushed out of
   // the msb by this edge, so it is taken once it has settled at the period end
   task automatic bit_xfer(input logic b, output logic q);
      sin_o <= b;
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'h1;
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'h0;
      q = serial_output_i;
   endtask
   // msb first; resending the latched word rereads status only
   task automatic shift_word(input logic [256:0] w, output logic [256:0] r);
      for (int i = 256; i >= 0; i--) bit_xfer(w[i], r[i]);
      // no pull on the data line: show the inverse once released
      sin_o <= ~w[0];
      @(posedge clk_i);
   endtask
   task automatic strobe();
      lat_o <= 1'h1;
      repeat (8) @(posedge clk_i);
      lat_o <= 1'h0;
      repeat (8) @(posedge clk_i);
   endtask
endmodule

// >>> bench/pss_top_tb_top.sv
// self-checking bench for power-save control and status readback
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_top_tb_top;
   typedef struct {logic [15:0] o; logic [15:0] s; logic [15:0] l; logic [2:0] t;
      logic [31:0] g;} pss_row_t;
   logic clk, rstn, grayscale_clock, sclk, lat, sin, serial_output, gs_int, ps, psel, pen, pwr, pready, perr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] opn, sht, lk;
   logic [2:0] th;
   logic [256:0] r;
   int mismatches, checked, cyc, n;
   pss_row_t rows [4] = '{'{16'h0, 16'h0, 16'h0, 3'h0, 32'h0},
      '{16'h8001, 16'h00FF, 16'hA5A5, 3'h5, 32'h1234ABCD},
      '{16'hFFFF, 16'hFF00, 16'h5A5A, 3'h2, 32'h1234ABCD},
      '{16'h3C3C, 16'hFFFF, 16'h0001, 3'h7, 32'hFFFFFFFF}};
   pss_top #(.WAKE_CYC(3)) pss_top_inst (.CLK_I(clk), .RSTN_I(rstn), .SCLK_I(sclk),
      .LAT_I(lat), .SIN_I(sin), .GRAYSCALE_CLOCK_I(grayscale_clock), .SERIAL_OUTPUT_O(serial_output), .OPEN_FLAG_I(opn),
      .SHORT_FLAG_I(sht), .LEAK_FLAG_I(lk), .TERR_FLAG_I(th[2]), .TWARN_FLAG_I(th[1]),
      .REFS_FLAG_I(th[0]), .GRAYSCALE_CLOCK_INT_O(gs_int), .POWER_SAVING_O(ps), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr));
   pss_host_model pss_host_model_inst (.clk_i(clk), .serial_output_i(serial_output), .sclk_o(sclk),
      .sin_o(sin), .lat_o(lat));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      grayscale_clock <= ~grayscale_clock;
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         mismatches++;
         stop_test();
      end
   end
   function automatic logic [256:0] img(pss_row_t x);
      img = '0;
      img[247:240] = x.o[15:8];
      img[231:224] = x.o[7:0];
      img[215:208] = x.s[15:8];
      img[199:192] = x.s[7:0];
      img[183:176] = x.l[15:8];
      img[167:160] = x.l[7:0];
      img[151:149] = x.t;
   endfunction
   task automatic chk(input string nm, input logic [256:0] ex, input logic [256:0] got);
      checked++;
      if (got !== ex) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // one idle edge after release keeps back-to-back calls apart
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic er);
      int t;
      psel <= 1'h1;
      pen <= 1'h0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'h1 && t < 50);
      if (t == 50) mismatches++;
      rd = prdata;
      er = perr;
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
   endtask
   task automatic toggles(output int c);
      logic p;
      c = 0;
      p = gs_int;
      repeat (40) begin
         @(posedge clk);
         if (gs_int !== p) c++;
         p = gs_int;
      end
   endtask
   task automatic stop_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      rstn = 1'h0;
      grayscale_clock = 1'h0;
      {psel, pen, pwr} = 3'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      {opn, sht, lk, th} = '0;
      repeat (5) @(posedge clk);
      chk("save at reset", 1, ps);
      rstn <= 1'h1;
      @(posedge clk);
      apb(1'h0, `PSS_APB_CTRL, 32'h0, q, e);
      chk("ctrl reset", 3'h7, q[2:0]);
      apb(1'h1, `PSS_APB_CTRL, 32'h0, q, e);
      toggles(n);
      chk("off mode", 0, ps);
      chk("grayscale_clock ungated", 1, n > 0);
      for (int k = 0; k < 4; k++) begin
         {opn, sht, lk, th} <= {rows[k].o, rows[k].s, rows[k].l, rows[k].t};
         pss_host_model_inst.shift_word({1'h0, {8{rows[k].g}}}, r);
         if (k > 0) chk("status", img(rows[k-1]), {1'h0, r[255:0]});
         pss_host_model_inst.strobe();
         apb(1'h0, `PSS_APB_GSLO, 32'h0, q, e);
         chk("gs latch", rows[k].g, q);
         chk("no save", 0, ps);
      end
      {opn, sht, lk, th} <= '0;
      @(posedge clk);
      pss_host_model_inst.strobe();
      pss_host_model_inst.shift_word({1'h1, {8{32'hC3C30F0F}}}, r);
      chk("refused reload", img(rows[3]), {1'h0, r[255:0]});
      pss_host_model_inst.strobe();
      pss_host_model_inst.shift_word('0, r);
      chk("msb skips load", {1'h1, {8{32'hC3C30F0F}}}, r);
      apb(1'h1, `PSS_APB_CTRL, 32'h2, q, e);
      pss_host_model_inst.strobe();
      toggles(n);
      chk("save on zero", 1, ps);
      chk("grayscale_clock in save", 1, n > 0);
      pss_host_model_inst.shift_word({1'h0, {8{32'h1}}}, r);
      chk("stay saved", 1, ps);
      pss_host_model_inst.strobe();
      repeat (8) @(posedge clk);
      chk("wake on data", 0, ps);
      apb(1'h1, `PSS_APB_CTRL, 32'h5, q, e);
      pss_host_model_inst.shift_word('0, r);
      pss_host_model_inst.strobe();
      toggles(n);
      chk("save mode 01", 1, ps);
      chk("grayscale_clock gated", 0, {n != 0, gs_int});
      pss_host_model_inst.bit_xfer(1'h1, e);
      repeat (8) @(posedge clk);
      chk("wake on shift", 0, ps);
      apb(1'h1, `PSS_APB_CTRL, 32'h7, q, e);
      repeat (4) @(posedge clk);
      chk("always save", 1, ps);
      apb(1'h0, 12'h00C, 32'h0, q, e);
      chk("unmapped", {1'h1, 32'h0}, {e, q});
      stop_test();
   end
endmodule
